/* File: gms_sequencer.sv */
`timescale 1ns/1ps
module gms_sequencer #(
    parameter int unsigned SLOT_CYC  = gms_pkg::SLOT_CYC,
    parameter int unsigned PRE_CYC   = gms_pkg::PRE_CYC,
    parameter int unsigned SLEEP_CYC = gms_pkg::SLEEP_CYC,
    parameter logic [7:0]  NV_SCALE  = gms_pkg::SCALE_RST,
    parameter logic [gms_pkg::PROF_N*16-1:0] NV_PROFILE = '0
) (
    input  wire logic         clk_sys,
    input  wire logic         rstn,
    input  wire logic         sclIn,
    input  wire logic         sdaIn,
    input  wire logic         linkClk,
    input  wire logic         linkRstn,
    input  wire logic         linkReq,
    input  wire logic         linkWr,
    input  wire logic [7:0]   linkAddr,
    input  wire logic [15:0]  linkWdata,
    output logic              linkBusy,
    output logic              linkDone,
    output logic [15:0]       linkRdata,
    output logic              adcStart,
    output gms_pkg::gms_ch_t  adcChan,
    input  wire logic         adcValid,
    input  wire logic [15:0]  adcResult,
    output logic              divSupplyOut,
    output logic              sleepMode
);
    localparam int unsigned SW = $clog2(SLOT_CYC);
    localparam int unsigned LW = $clog2(SLEEP_CYC);

    // Aux slot that really samples an external divider
    function automatic logic needsDiv(input gms_pkg::gms_slot_t s, input logic t);
        needsDiv = (s == gms_pkg::SL_AUX0) || (s == gms_pkg::SL_AUX1 && !t);
    endfunction

    // Channel converted in a slot; gap slots convert nothing
    function automatic gms_pkg::gms_ch_t chanOf(input gms_pkg::gms_slot_t s,
                                                input logic t);
        case (s)
            gms_pkg::SL_VOLT0, gms_pkg::SL_VOLT1: chanOf = gms_pkg::CH_VOLT;
            gms_pkg::SL_CURR0, gms_pkg::SL_CURR1: chanOf = gms_pkg::CH_CURR;
            gms_pkg::SL_AUX0: chanOf = gms_pkg::CH_AUX0;
            gms_pkg::SL_AUX1: chanOf = t ? gms_pkg::CH_TEMP : gms_pkg::CH_AUX1;
            default: chanOf = gms_pkg::CH_NONE;
        endcase
    endfunction

    logic [1:0]           lineS;
    logic                 anyHigh;
    logic                 active;
    gms_pkg::gms_pm_t     pm_q;
    logic [LW-1:0]        lowCnt_q;
    logic [SW-1:0]        slotCnt_q;
    logic                 slotEnd;
    gms_pkg::gms_slot_t   slot_q;
    gms_pkg::gms_slot_t   nxtSlot;
    logic                 tempUse_q;
    logic                 divOn_d;
    logic                 divOn_q;
    gms_pkg::gms_ch_t     chan_q;
    logic                 cfgSleep_q;
    logic                 cfgTemp_q;
    logic [7:0]           scale_q;
    logic [15:0]          prof_q [gms_pkg::PROF_N];
    logic [15:0]          volt_q;
    logic [15:0]          curr_q;
    logic [15:0]          aux0_q;
    logic [15:0]          aux1_q;
    logic [15:0]          temp_q;
    logic [15:0]          cap_q;
    logic [31:0]          acc_q;
    logic [31:0]          curExt;
    logic signed [24:0]   prod;
    logic [15:0]          rdVal;
    logic [15:0]          rdHold_q;
    logic                 reqS;
    logic                 reqSeen_q;
    logic                 hostGo;
    logic                 hostWr;
    logic                 ackT_q;
    logic                 ackS;
    logic                 ackSeen_q;
    logic                 reqT_q;
    logic                 busy_q;
    logic                 done_q;
    logic                 lkWr_q;
    logic [7:0]           lkAddr_q;
    logic [15:0]          lkWdata_q;
    logic [15:0]          rd_q;

    // Bus lines are pins, so they cross before any logic sees them
    gms_sync #(.W(2)) uLineSync (
        .clk  (clk_sys),
        .rstn (rstn),
        .d    ({sclIn, sdaIn}),
        .q    (lineS)
    );

    assign anyHigh   = |lineS;
    assign active    = (pm_q == gms_pkg::PM_ACTIVE);
    assign sleepMode = !active;

    // low timer restart
    // Counting only while sleep is allowed avoids a stale count arming Sleep
    always_ff @(posedge clk_sys) begin
        if (!rstn || anyHigh || !active || !cfgSleep_q) begin
            lowCnt_q <= '0;
        end else if (lowCnt_q != LW'(SLEEP_CYC - 1)) begin
            lowCnt_q <= lowCnt_q + 1'b1;
        end
    end

    // Power mode
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pm_q <= gms_pkg::PM_ACTIVE;
        end else begin
            case (pm_q)
                gms_pkg::PM_ACTIVE: begin
                    if (cfgSleep_q && !anyHigh && lowCnt_q == LW'(SLEEP_CYC - 1)) begin
                        pm_q <= gms_pkg::PM_SLEEP;
                    end
                end
                gms_pkg::PM_SLEEP: begin
                    if (anyHigh) begin
                        pm_q <= gms_pkg::PM_ACTIVE;
                    end
                end
                default: pm_q <= gms_pkg::PM_ACTIVE;
            endcase
        end
    end

    assign slotEnd = (slotCnt_q == SW'(SLOT_CYC - 1));
    assign nxtSlot = gms_pkg::gms_slot_t'(slot_q + 3'h1);

    // endless pass timebase
    // Sleep parks the pass at its start, so each wake begins a full pass
    always_ff @(posedge clk_sys) begin
        if (!rstn || !active) begin
            slotCnt_q <= '0;
            slot_q    <= gms_pkg::SL_VOLT0;
        end else if (slotEnd) begin
            slotCnt_q <= '0;
            slot_q    <= nxtSlot;
        end else begin
            slotCnt_q <= slotCnt_q + 1'b1;
        end
    end

    // temperature select latch
    // Taken only between passes so a slot never changes channel halfway
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            tempUse_q <= gms_pkg::CFG_TEMP_RST;
        end else if (!active || (slotEnd && slot_q == gms_pkg::SL_GAP1)) begin
            tempUse_q <= cfgTemp_q;
        end
    end

    always_comb begin
        divOn_d = active && ((needsDiv(slot_q, tempUse_q) && !slotEnd) ||
                  (needsDiv(nxtSlot, tempUse_q) &&
                   slotCnt_q >= SW'(SLOT_CYC - PRE_CYC - 1)));
    end

    // Registered so the pin never glitches between slots
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            divOn_q <= 1'b0;
        end else begin
            divOn_q <= divOn_d;
        end
    end

    // Channel tag for the converter, aligned with the slot boundary
    always_ff @(posedge clk_sys) begin
        if (!rstn || !active) begin
            chan_q <= gms_pkg::CH_VOLT;
        end else begin
            chan_q <= chanOf(slotEnd ? nxtSlot : slot_q, tempUse_q);
        end
    end

    assign adcStart     = active && slotCnt_q == '0 &&
                          chanOf(slot_q, tempUse_q) != gms_pkg::CH_NONE;
    assign adcChan      = chan_q;
    assign divSupplyOut = divOn_q;

    assign curExt = 32'(signed'(adcResult[10:0]));
    assign prod   = $signed(acc_q[23:8]) * $signed({1'b0, scale_q});

    // result registers
    // A conversion beats a host write in the same cycle: fresh data wins
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            volt_q <= '0;
            curr_q <= '0;
            aux0_q <= '0;
            aux1_q <= '0;
            temp_q <= '0;
            cap_q  <= '0;
        end else if (adcValid && active) begin
            case (chan_q)
                gms_pkg::CH_VOLT: volt_q <= {4'h0, adcResult[11:0]} << gms_pkg::VOLT_SH;
                gms_pkg::CH_CURR: begin
                    curr_q <= curExt[15:0] << gms_pkg::MEAS11_SH;
                    cap_q  <= prof_q[volt_q[14:11]] + prod[23:8];
                end
                gms_pkg::CH_AUX0: aux0_q <= {5'h00, adcResult[10:0]} << gms_pkg::MEAS11_SH;
                gms_pkg::CH_AUX1: aux1_q <= {5'h00, adcResult[10:0]} << gms_pkg::MEAS11_SH;
                gms_pkg::CH_TEMP: temp_q <= {5'h00, adcResult[10:0]} << gms_pkg::MEAS11_SH;
                default: ;
            endcase
        end else if (hostWr) begin
            case (lkAddr_q)
                gms_pkg::A_VOLT: volt_q <= lkWdata_q;
                gms_pkg::A_CURR: curr_q <= lkWdata_q;
                gms_pkg::A_AUX0: aux0_q <= lkWdata_q;
                gms_pkg::A_AUX1: aux1_q <= lkWdata_q;
                gms_pkg::A_TEMP: temp_q <= lkWdata_q;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            acc_q <= '0;
        end else if (adcValid && active && chan_q == gms_pkg::CH_CURR) begin
            acc_q <= acc_q + curExt;
        end else if (hostWr && lkAddr_q == gms_pkg::A_ACCH) begin
            acc_q[31:16] <= lkWdata_q;
        end else if (hostWr && lkAddr_q == gms_pkg::A_ACCL) begin
            acc_q[15:0] <= lkWdata_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cfgSleep_q <= gms_pkg::CFG_SLEEP_RST;
            cfgTemp_q  <= gms_pkg::CFG_TEMP_RST;
            scale_q    <= NV_SCALE;
            for (int i = 0; i < gms_pkg::PROF_N; i++) begin
                prof_q[i] <= NV_PROFILE[16*i +: 16];
            end
        end else if (hostWr) begin
            if (lkAddr_q == gms_pkg::A_CFG) begin
                cfgSleep_q <= lkWdata_q[gms_pkg::CFG_SLEEP];
                cfgTemp_q  <= lkWdata_q[gms_pkg::CFG_TEMP];
            end
            if (lkAddr_q == gms_pkg::A_SCALE) begin
                scale_q <= lkWdata_q[7:0];
            end
            if (lkAddr_q[7:4] == gms_pkg::A_PROF[7:4]) begin
                prof_q[lkAddr_q[3:0]] <= lkWdata_q;
            end
        end
    end

    always_comb begin
        rdVal = 16'h0000;
        case (lkAddr_q)
            gms_pkg::A_CFG: begin
                rdVal[gms_pkg::CFG_SLEEP] = cfgSleep_q;
                rdVal[gms_pkg::CFG_TEMP]  = cfgTemp_q;
                rdVal[gms_pkg::CFG_ACT]   = active;
            end
            gms_pkg::A_VOLT:  rdVal = volt_q;
            gms_pkg::A_CURR:  rdVal = curr_q;
            gms_pkg::A_AUX0:  rdVal = aux0_q;
            gms_pkg::A_AUX1:  rdVal = aux1_q;
            gms_pkg::A_TEMP:  rdVal = temp_q;
            gms_pkg::A_ACCH:  rdVal = acc_q[31:16];
            gms_pkg::A_ACCL:  rdVal = acc_q[15:0];
            gms_pkg::A_SCALE: rdVal = {8'h00, scale_q};
            gms_pkg::A_CAP:   rdVal = cap_q;
            default: begin
                if (lkAddr_q[7:4] == gms_pkg::A_PROF[7:4]) begin
                    rdVal = prof_q[lkAddr_q[3:0]];
                end
            end
        endcase
    end

    // Request toggle from the link crosses in
    gms_sync #(.W(1)) uReqSync (
        .clk  (clk_sys),
        .rstn (rstn),
        .d    (reqT_q),
        .q    (reqS)
    );

    assign hostGo = (reqS != reqSeen_q);
    assign hostWr = hostGo && lkWr_q;

    // serve host any mode
    // Link request words stay frozen until the ack toggle gets back
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            reqSeen_q <= 1'b0;
            ackT_q    <= 1'b0;
            rdHold_q  <= '0;
        end else if (hostGo) begin
            reqSeen_q <= reqS;
            ackT_q    <= !ackT_q;
            rdHold_q  <= rdVal;
        end
    end

    // Ack toggle crosses back into the link domain
    gms_sync #(.W(1)) uAckSync (
        .clk  (linkClk),
        .rstn (linkRstn),
        .d    (ackT_q),
        .q    (ackS)
    );

    // Request capture on the link clock
    always_ff @(posedge linkClk) begin
        if (!linkRstn) begin
            lkWr_q    <= 1'b0;
            lkAddr_q  <= '0;
            lkWdata_q <= '0;
        end else if (linkReq && !busy_q) begin
            lkWr_q    <= linkWr;
            lkAddr_q  <= linkAddr;
            lkWdata_q <= linkWdata;
        end
    end

    // link handshake
    // The link clock must keep running while busy, or the ack is never seen
    always_ff @(posedge linkClk) begin
        if (!linkRstn) begin
            reqT_q    <= 1'b0;
            busy_q    <= 1'b0;
            done_q    <= 1'b0;
            ackSeen_q <= 1'b0;
            rd_q      <= '0;
        end else begin
            done_q <= 1'b0;
            if (linkReq && !busy_q) begin
                reqT_q <= !reqT_q;
                busy_q <= 1'b1;
            end else if (busy_q && ackS != ackSeen_q) begin
                ackSeen_q <= ackS;
                busy_q    <= 1'b0;
                done_q    <= 1'b1;
                rd_q      <= rdHold_q;
            end
        end
    end

    assign linkBusy  = busy_q;
    assign linkDone  = done_q;
    assign linkRdata = rd_q;

    // Named steps reused below
    sequence sFallAsleep;
        active ##1 !active;
    endsequence

    sequence sLeadIn;
        $rose(divOn_q) && slotCnt_q == SW'(SLOT_CYC - PRE_CYC);
    endsequence

    a_wake_line: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (!active && anyHigh) |=> active)
        else $error("gauge stayed asleep with a bus line high");

    a_sleep_gate: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        sFallAsleep |-> $past(cfgSleep_q) && !$past(anyHigh))
        else $error("sleep entered without permission or with a line high");

    a_timeout_len: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        sFallAsleep |-> $past(lowCnt_q) == LW'(SLEEP_CYC - 1))
        else $error("sleep entered before the bus-low timeout ran out");

    a_timer_restart: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        anyHigh |=> lowCnt_q == '0)
        else $error("bus-low timer kept counting after a line went high");

    a_sleep_quiet: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (!active ##1 !active) |-> !adcStart && !divOn_q)
        else $error("conversion or divider activity during sleep");

    a_sleep_hold: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (!active && !hostGo) |=> $stable(volt_q) && $stable(curr_q) && $stable(acc_q))
        else $error("results changed during sleep without a host write");

    a_host_write: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (hostWr && lkAddr_q == gms_pkg::A_SCALE) |=> scale_q == $past(lkWdata_q[7:0]))
        else $error("host write to the scale shadow was lost");

    a_link_take: assert property (
        @(posedge linkClk) disable iff (!linkRstn)
        (linkReq && !linkBusy) |=> linkBusy && lkAddr_q == $past(linkAddr))
        else $error("link request was not taken");

    a_seq_wrap: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (slotEnd && slot_q == gms_pkg::SL_GAP1 ##1 active)
        |-> slot_q == gms_pkg::SL_VOLT0 && adcStart)
        else $error("pass did not restart after its last slot");

    a_div_lead: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        sLeadIn |-> needsDiv(nxtSlot, tempUse_q))
        else $error("divider supply rose at the wrong lead time");

    a_temp_nodiv: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (slot_q == gms_pkg::SL_AUX1 && tempUse_q) |-> !divOn_q)
        else $error("divider supply on during the temperature slot");

    a_acc_add: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        (adcValid && active && chan_q == gms_pkg::CH_CURR)
        |=> acc_q == $past(acc_q) + $past(curExt))
        else $error("current result not added to the accumulator");
endmodule

/* File: gms_pkg.sv */
package gms_pkg;
    // Timebase
    localparam int unsigned CLK_KHZ      = 25000;
    localparam int unsigned PASS_MS      = 1760;
    localparam int unsigned SLOTS        = 8;
    localparam int unsigned PASS_CYC     = PASS_MS * CLK_KHZ;
    localparam int unsigned SLOT_CYC     = PASS_CYC / SLOTS;
    // Precharge lead is a least time, so it rounds up
    localparam int unsigned PRE_US       = 13200;
    localparam int unsigned PRE_CYC      = (PRE_US * CLK_KHZ + 999) / 1000;
    // Bus-low timeout window; the low end is used, exact in cycles
    localparam int unsigned SLEEP_MIN_MS = 1500;
    localparam int unsigned SLEEP_MAX_MS = 2200;
    localparam int unsigned SLEEP_CYC    = SLEEP_MIN_MS * CLK_KHZ;
    // Register addresses, one 16-bit word each
    localparam logic [7:0]  A_CFG        = 8'h00;
    localparam logic [7:0]  A_VOLT       = 8'h01;
    localparam logic [7:0]  A_CURR       = 8'h02;
    localparam logic [7:0]  A_AUX0       = 8'h03;
    localparam logic [7:0]  A_AUX1       = 8'h04;
    localparam logic [7:0]  A_TEMP       = 8'h05;
    localparam logic [7:0]  A_ACCH       = 8'h06;
    localparam logic [7:0]  A_ACCL       = 8'h07;
    localparam logic [7:0]  A_SCALE      = 8'h08;
    localparam logic [7:0]  A_CAP        = 8'h09;
    localparam logic [7:0]  A_PROF       = 8'h10;
    localparam int          PROF_N       = 16;
    // Config fields and reset values
    localparam int          CFG_SLEEP    = 0;
    localparam int          CFG_TEMP     = 1;
    localparam int          CFG_ACT      = 7;
    localparam logic        CFG_SLEEP_RST = 1'b0;
    localparam logic        CFG_TEMP_RST = 1'b0;
    localparam logic [7:0]  SCALE_RST    = 8'h80;
    // Result alignment inside the 16-bit words
    localparam int          VOLT_SH      = 3;
    localparam int          MEAS11_SH    = 5;

    typedef enum logic [2:0] {
        SL_VOLT0, SL_CURR0, SL_AUX0, SL_GAP0,
        SL_VOLT1, SL_CURR1, SL_AUX1, SL_GAP1
    } gms_slot_t;
    typedef enum logic [2:0] {
        CH_VOLT, CH_CURR, CH_AUX0, CH_AUX1, CH_TEMP, CH_NONE
    } gms_ch_t;
    typedef enum logic {PM_ACTIVE, PM_SLEEP} gms_pm_t;
endpackage

/* File: gms_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser; the first stage feeds only the second
module gms_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    // Both stages clear on the domain's own synchronous reset
    always_ff @(posedge clk) begin
        if (!rstn) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

/* File: gms_host_model.sv */
`timescale 1ns/1ps
// Host side: bus line levels and word access over the link
module gms_host_model (
    input  wire logic        linkClk,
    input  wire logic        linkBusy,
    input  wire logic        linkDone,
    input  wire logic [15:0] linkRdata,
    output logic             linkReq,
    output logic             linkWr,
    output logic [7:0]       linkAddr,
    output logic [15:0]      linkWdata,
    output logic             sclIn,
    output logic             sdaIn
);
    int timeouts = 0;
    // lines idle high
    // Idle high keeps the gauge awake unless the bench wants it asleep
    initial begin
        {linkReq, linkWr, linkAddr, linkWdata} = '0;
        {sclIn, sdaIn} = 2'b11;
    end
    // Set both bus line levels
    task automatic lines(input logic s, input logic d);
        {sclIn, sdaIn} = {s, d};
    endtask
    // word access
    // One word each; the request stands only for its taking edge
    task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] wd,
                          output logic [15:0] rd);
        int n;
        n = 0;
        @(posedge linkClk);
        #2;
        {linkReq, linkWr, linkAddr, linkWdata} = {1'b1, wr, a, wd};
        @(posedge linkClk);
        #2;
        // Released fields show a pattern, never the last value
        {linkReq, linkWr, linkAddr, linkWdata} = {1'b0, ~wr, ~a, ~wd};
        while (linkDone !== 1'b1 && n < 20) begin
            @(posedge linkClk);
            #1;
            n++;
        end
        if (n >= 20) timeouts++;
        rd = linkRdata;
    endtask
endmodule

/* File: gms_sequencer_tb.sv */
`timescale 1ns/1ps
module gms_sequencer_tb;
    localparam int SLOT = 64;
    localparam int SLP  = 100;
    logic             clk_sys = 0, linkClk = 0, rstn = 0, linkRstn = 0, adcValid = 0;
    logic [15:0]      adcResult = '0, rd;
    logic             linkReq, linkWr, sclIn, sdaIn, linkBusy, linkDone;
    logic             adcStart, divSupplyOut, sleepMode;
    logic [7:0]       linkAddr;
    logic [15:0]      linkWdata, linkRdata;
    gms_pkg::gms_ch_t adcChan;
    int               fail_count = 0, samples_checked = 0;

    gms_sequencer #(.SLOT_CYC(SLOT), .PRE_CYC(8), .SLEEP_CYC(SLP)) u_gms_sequencer (
        .clk_sys(clk_sys), .rstn(rstn), .sclIn(sclIn), .sdaIn(sdaIn),
        .linkClk(linkClk), .linkRstn(linkRstn), .linkReq(linkReq), .linkWr(linkWr),
        .linkAddr(linkAddr), .linkWdata(linkWdata), .linkBusy(linkBusy),
        .linkDone(linkDone), .linkRdata(linkRdata), .adcStart(adcStart),
        .adcChan(adcChan), .adcValid(adcValid), .adcResult(adcResult),
        .divSupplyOut(divSupplyOut), .sleepMode(sleepMode));
    gms_host_model u_gms_host_model (
        .linkClk(linkClk), .linkBusy(linkBusy), .linkDone(linkDone),
        .linkRdata(linkRdata), .linkReq(linkReq), .linkWr(linkWr), .linkAddr(linkAddr),
        .linkWdata(linkWdata), .sclIn(sclIn), .sdaIn(sdaIn));

    // Two clocks with unrelated periods
    always #20 clk_sys = ~clk_sys;
    always #32 linkClk = ~linkClk;

    // Fixed raw converter code per channel
    function automatic logic [15:0] raw(input gms_pkg::gms_ch_t c);
        case (c)
            gms_pkg::CH_VOLT: return 16'h0ABC;
            gms_pkg::CH_CURR: return 16'h0401;
            gms_pkg::CH_AUX0: return 16'h0123;
            gms_pkg::CH_TEMP: return 16'h0567;
            default:          return 16'h0345;
        endcase
    endfunction

    // Converter: answers three cycles after each start
    always begin
        @(posedge clk_sys);
        #2;
        if (adcStart === 1'b1 && rstn) begin
            adcResult = raw(adcChan);
            repeat (3) @(posedge clk_sys);
            #2 adcValid = 1'b1;
            @(posedge clk_sys);
            #2 adcValid = 1'b0;
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        fail_count += u_gms_host_model.timeouts;
        $display("Counts: checked=%0d failed=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Bounded wait for a conversion start on one channel
    task automatic wait_chan(input gms_pkg::gms_ch_t c);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (!(adcStart === 1'b1 && adcChan === c) && n < 1200);
        if (n >= 1200) begin
            fail_count++;
            give_verdict();
        end
    endtask

    task automatic t_results();
        logic [15:0] v, c, a, b;
        v = raw(gms_pkg::CH_VOLT);
        c = raw(gms_pkg::CH_CURR);
        a = raw(gms_pkg::CH_AUX0);
        b = raw(gms_pkg::CH_AUX1);
        wait_chan(gms_pkg::CH_AUX0);
        check({15'h0, divSupplyOut}, 16'h0001);
        wait_chan(gms_pkg::CH_VOLT);
        check({15'h0, divSupplyOut}, 16'h0000);
        // Let the conversion land first, or the read may race its update
        repeat (10) @(posedge clk_sys);
        u_gms_host_model.access(1'b0, gms_pkg::A_VOLT, 16'h0000, rd);
        check(rd, {1'b0, v[11:0], 3'b000});
        u_gms_host_model.access(1'b0, gms_pkg::A_CURR, 16'h0000, rd);
        check(rd, {c[10:0], 5'h00});
        u_gms_host_model.access(1'b0, gms_pkg::A_AUX0, 16'h0000, rd);
        check(rd, {a[10:0], 5'h00});
        wait_chan(gms_pkg::CH_AUX1);
        check({15'h0, divSupplyOut}, 16'h0001);
        repeat (10) @(posedge clk_sys);
        u_gms_host_model.access(1'b0, gms_pkg::A_AUX1, 16'h0000, rd);
        check(rd, {b[10:0], 5'h00});
        $display("t_results done");
    endtask

    task automatic t_temp();
        logic [15:0] t;
        t = raw(gms_pkg::CH_TEMP);
        u_gms_host_model.access(1'b1, gms_pkg::A_SCALE, 16'h005A, rd);
        u_gms_host_model.access(1'b0, gms_pkg::A_SCALE, 16'h0000, rd);
        check(rd, 16'h005A);
        u_gms_host_model.access(1'b1, gms_pkg::A_CFG, 16'h0002, rd);
        wait_chan(gms_pkg::CH_TEMP);
        check({15'h0, divSupplyOut}, 16'h0000);
        repeat (10) @(posedge clk_sys);
        u_gms_host_model.access(1'b0, gms_pkg::A_TEMP, 16'h0000, rd);
        check(rd, {t[10:0], 5'h00});
        u_gms_host_model.access(1'b1, gms_pkg::A_CFG, 16'h0000, rd);
        $display("t_temp done");
    endtask

    task automatic t_sleep();
        int n, starts;
        logic [15:0] v;
        v = raw(gms_pkg::CH_VOLT);
        starts = 0;
        u_gms_host_model.access(1'b1, gms_pkg::A_CFG, 16'h0001, rd);
        @(posedge clk_sys);
        #2 u_gms_host_model.lines(1'b0, 1'b0);
        repeat (SLP - 20) @(posedge clk_sys);
        #2 u_gms_host_model.lines(1'b1, 1'b0);
        repeat (3) @(posedge clk_sys);
        #2 u_gms_host_model.lines(1'b0, 1'b0);
        repeat (SLP - 10) @(posedge clk_sys);
        #1 check({15'h0, sleepMode}, 16'h0000);
        for (n = 0; n < 40 && sleepMode !== 1'b1; n++) begin
            @(posedge clk_sys);
            #1;
        end
        check({15'h0, sleepMode}, 16'h0001);
        for (n = 0; n < 200; n++) begin
            @(posedge clk_sys);
            #1 if (adcStart === 1'b1) starts++;
        end
        check(16'(starts), 16'h0000);
        u_gms_host_model.access(1'b0, gms_pkg::A_VOLT, 16'h0000, rd);
        check(rd, {1'b0, v[11:0], 3'b000});
        u_gms_host_model.access(1'b0, gms_pkg::A_CFG, 16'h0000, rd);
        check(rd, 16'h0001);
        @(posedge clk_sys);
        #2 u_gms_host_model.lines(1'b0, 1'b1);
        for (n = 0; n < 6 && sleepMode !== 1'b0; n++) begin
            @(posedge clk_sys);
            #1;
        end
        check({15'h0, sleepMode}, 16'h0000);
        #1 u_gms_host_model.lines(1'b1, 1'b1);
        u_gms_host_model.access(1'b1, gms_pkg::A_CFG, 16'h0000, rd);
        $display("t_sleep done");
    endtask

    // Main sequence after both resets
    initial begin
        repeat (16) @(posedge clk_sys);
        #2;
        rstn = 1'b1;
        linkRstn = 1'b1;
        t_results();
        t_temp();
        t_sleep();
        give_verdict();
    end
endmodule
